/* verilog/fsq_seq.sv */
/*
  Serial flash command sequencer: read family and status-2 write.
  Assumes the host drives cs_n, sck and lanes per SPI mode 0/3, the rest of the
  device supplies write_enable_latch and busy on clk_sys, and the array is
  preloaded over the load port. Lane outputs are resolved by the bench wires.
*/
// Summary of operation
// [RL1] 31h updates only protect and quad bits
// [RL2] Status-2 write acts only with latch set
// [RL3] Host sends 31h then exactly one byte
// [RL4] Read 03h: opcode, 24-bit address, MSB first
// [RL5] Data driven MSB first on falling edges
// [RL6] Address increments per byte until deselect
// [RL7] Read 03h ignored entirely while busy
// [RL8] Fast read: address, dummies, then data
// [RL9] Four-wire fast read dummies from P[5:4]
// [RL10] Dummy count four after reset
// [RL11] Dual output: eight dummies, two lanes
// [RL12] Quad output refused unless quad enable
// [RL13] Quad output: eight dummies, four lanes
// [RL14] Host releases lanes before data out
// [RL15] Dual I/O: address, mode, data, two lanes
// [RL16] Only upper mode nibble matters
// [RL17] Dual I/O Ax skips next opcode
// [RL18] Quad I/O Ax skips next opcode
// [RL19] Other nibble leaves continuous mode
// [RL20] Mode reset frame clears continuous mode
// [RL21] Quad I/O accepted only with quad enable
// [RL22] Dual data: odd bits lane 1
// [RL23] Dual address: odd bits lane 1
// [RL24] Quad address: lane n carries bit n
// [RL25] Single-lane fast read: eight dummies
// [RL26] P[5:4] 00/01/10 give 4/6/8 dummies
// [RL27] Quad I/O single-lane: four dummies after mode
`timescale 1ns/10ps
module fsq_seq
  import fsq_pkg::*;
(
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic sck, // Serial clock from the host.
  input wire logic cs_n, // Chip select, active low.
  input wire logic [3:0] lane_in, // Lane levels seen at the pins.
  output logic [3:0] lane_out, // Lane drive values.
  output logic [3:0] lane_oe_n, // Lane output enables, low drives.
  input wire logic write_enable_latch, // Latch state from the device.
  input wire logic busy, // Program, erase or status cycle running.
  input wire logic four_wire_command_mode, // Four-wire command mode active.
  input wire logic reset_cmd, // Reset command pulse.
  input wire logic load_en, // Array preload strobe.
  input wire logic [MEM_AW-1:0] load_addr, // Array preload address.
  input wire logic [7:0] load_data, // Array preload byte.
  output fsq_sr2_t sr2, // Non-volatile status-2 bits.
  output logic [1:0] read_param_dummy, // Dummy select bits P[5:4].
  output logic sr2_write_done // Pulse when status-2 was written.
);
  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [23:0] shift_in(logic [23:0] v, logic [1:0] w, logic [3:0] io);
    case (w)
      W2: shift_in = {v[21:0], io[1], io[0]}; // [RL23]
      W4: shift_in = {v[19:0], io[3:0]}; // [RL24]
      default: shift_in = {v[22:0], io[0]}; // [RL4]
    endcase
  endfunction

  function automatic logic [4:0] clocks(logic [4:0] bits, logic [1:0] w);
    clocks = 5'(bits >> w);
  endfunction

  function automatic logic [4:0] rp_dummy(logic [1:0] sel);
    case (sel)
      2'b00: rp_dummy = DUMMY_RP0; // [RL26]
      2'b01: rp_dummy = DUMMY_RP1; // [RL26]
      default: rp_dummy = DUMMY_RP2; // [RL26]
    endcase
  endfunction

  // ***************************************************************
  // Array, written on clk_sys and read at the link
  // ***************************************************************
  logic [7:0] mem [0:(1<<MEM_AW)-1];
  always_ff @(posedge clk_sys) begin
    if (load_en) begin
      mem[load_addr] <= load_data;
    end
  end

  // ***************************************************************
  // Link side state
  // ***************************************************************
  fsq_state_t st_q, st_d;
  logic first_q, first_d;
  logic [7:0] op_q, op_d;
  logic [1:0] w_q, w_d;
  logic [1:0] dw_q, dw_d;
  logic mode_q, mode_d;
  logic [4:0] dum_q, dum_d;
  logic [4:0] cnt_q, cnt_d;
  logic [23:0] sh_q, sh_d;
  logic [MEM_AW-1:0] ra_q, ra_d;
  logic [2:0] beat_q, beat_d;
  logic cont_q, cont_d;
  logic [7:0] cont_op_q, cont_op_d;
  logic sr2_tgl_q, sr2_tgl_d;
  logic rp_tgl_q, rp_tgl_d;
  logic [7:0] evt_byte_q, evt_byte_d;
  fsq_cfg_t cfg_s1_q, cfg_s2_q, cfg_sys_q, cfg_sys_d;
  logic frm_rst;
  logic [23:0] nx;
  logic [23:0] cmd_sh;
  logic [1:0] cw, aw;
  logic [7:0] dop;
  logic [4:0] dum_c;
  logic [1:0] dw_c;
  logic mode_c, ok_c, byte_c;

  // Deselect ends the frame at once, since sck may stop before cs_n rises.
  assign frm_rst = rst | cs_n;

  // Settings for the opcode about to start, either decoded or remembered.
  always_comb begin
    cw = cfg_s2_q.four_wire ? W4 : W1;
    nx = shift_in(sh_q, w_q, lane_in);
    cmd_sh = shift_in(sh_q, cw, lane_in);
    dop = (first_q && cont_q) ? cont_op_q : cmd_sh[7:0];
    aw = cw;
    dum_c = DUMMY_STD;
    dw_c = W1;
    mode_c = 1'b0;
    ok_c = 1'b1;
    byte_c = 1'b0;
    case (dop)
      OP_READ: begin
        dum_c = 5'd0;
        ok_c = ~cfg_s2_q.busy; // [RL7]
      end
      OP_FAST: begin
        dum_c = cfg_s2_q.four_wire ? rp_dummy(cfg_s2_q.dsel) : DUMMY_STD; // [RL8] [RL9] [RL25]
        dw_c = cw;
      end
      OP_DUAL_OUT: dw_c = W2; // [RL11]
      OP_QUAD_OUT: begin
        dw_c = W4; // [RL13]
        ok_c = cfg_s2_q.quad_en; // [RL12]
      end
      OP_DUAL_IO: begin
        aw = W2; // [RL15]
        dw_c = W2;
        mode_c = 1'b1;
        dum_c = 5'd0;
      end
      OP_QUAD_IO: begin
        aw = W4;
        dw_c = W4;
        mode_c = 1'b1;
        ok_c = cfg_s2_q.quad_en; // [RL21]
        dum_c = cfg_s2_q.four_wire ? 5'(rp_dummy(cfg_s2_q.dsel) - QIO_MODE_CLKS)
                                   : DUMMY_QIO; // [RL27]
      end
      OP_WR_SR2: byte_c = 1'b1; // [RL3]
      OP_SET_RP: byte_c = 1'b1;
      default: ok_c = 1'b0;
    endcase
  end

  always_comb begin
    st_d = st_q;
    first_d = 1'b0;
    op_d = op_q;
    w_d = w_q;
    dw_d = dw_q;
    mode_d = mode_q;
    dum_d = dum_q;
    cnt_d = 5'(cnt_q + 5'd1);
    sh_d = nx;
    ra_d = ra_q;
    beat_d = beat_q;
    cont_d = cont_q;
    cont_op_d = cont_op_q;
    sr2_tgl_d = sr2_tgl_q;
    rp_tgl_d = rp_tgl_q;
    evt_byte_d = evt_byte_q;
    case (st_q)
      ST_CMD: begin
        if (first_q && cont_q) begin
          // An aborted frame never re-arms this, which is the mode reset.
          cont_d = 1'b0; // [RL17] [RL18] [RL20]
          op_d = dop;
          w_d = aw;
          dw_d = dw_c;
          mode_d = 1'b1;
          dum_d = dum_c;
          sh_d = shift_in(sh_q, aw, lane_in);
          st_d = ST_ADDR;
        end else begin
          sh_d = shift_in(sh_q, cw, lane_in);
          if (cnt_q == 5'(clocks(BYTE_BITS, cw) - 5'd1)) begin
            cnt_d = 5'd0;
            op_d = dop;
            w_d = byte_c ? cw : aw;
            dw_d = dw_c;
            mode_d = mode_c;
            dum_d = dum_c;
            if (!ok_c) begin
              st_d = ST_BYTE;
              op_d = 8'h00;
              cnt_d = 5'd31;
            end else begin
              st_d = byte_c ? ST_BYTE : ST_ADDR;
            end
          end
        end
      end
      ST_ADDR: begin
        if (cnt_q == 5'(clocks(ADDR_BITS, w_q) - 5'd1)) begin
          cnt_d = 5'd0;
          ra_d = nx[MEM_AW-1:0];
          beat_d = 3'd0;
          st_d = mode_q ? ST_MODE : (dum_q != 5'd0) ? ST_DUMMY : ST_DATA; // [RL8] [RL15]
        end
      end
      ST_MODE: begin
        if (cnt_q == 5'(clocks(BYTE_BITS, w_q) - 5'd1)) begin
          cnt_d = 5'd0;
          cont_d = (nx[7:4] == CONT_NIBBLE); // [RL16] [RL19]
          cont_op_d = op_q;
          st_d = (dum_q != 5'd0) ? ST_DUMMY : ST_DATA;
        end
      end
      ST_DUMMY: begin
        if (cnt_q == 5'(dum_q - 5'd1)) begin
          st_d = ST_DATA; // [RL8]
        end
      end
      ST_DATA: begin
        beat_d = 3'(beat_q + 3'd1);
        if ({2'b00, beat_q} == 5'(clocks(BYTE_BITS, dw_q) - 5'd1)) begin
          beat_d = 3'd0;
          ra_d = MEM_AW'(ra_q + 1'b1); // [RL6]
        end
      end
      ST_BYTE: begin
        // Also the sink for refused or unknown commands, with op cleared.
        if (cnt_q == 5'(clocks(BYTE_BITS, w_q) - 5'd1) && op_q != 8'h00) begin
          evt_byte_d = nx[7:0];
          if (op_q == OP_WR_SR2) begin
            sr2_tgl_d = ~sr2_tgl_q;
          end else begin
            rp_tgl_d = ~rp_tgl_q;
          end
          op_d = 8'h00;
        end
        if (cnt_q == 5'd31) begin
          cnt_d = 5'd31;
        end
      end
      default: st_d = ST_BYTE;
    endcase
  end

  always_ff @(posedge sck or posedge frm_rst) begin
    if (frm_rst) begin
      st_q <= ST_CMD;
      first_q <= 1'b1;
      op_q <= 8'h00;
      w_q <= W1;
      dw_q <= W1;
      mode_q <= 1'b0;
      dum_q <= 5'd0;
      cnt_q <= 5'd0;
      sh_q <= 24'h000000;
      ra_q <= '0;
      beat_q <= 3'd0;
    end else begin
      st_q <= st_d;
      first_q <= first_d;
      op_q <= op_d;
      w_q <= w_d;
      dw_q <= dw_d;
      mode_q <= mode_d;
      dum_q <= dum_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ra_q <= ra_d;
      beat_q <= beat_d;
    end
  end

  // The sync only moves on sck edges; settings must be stable a frame ahead.
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      cont_q <= 1'b0;
      cont_op_q <= 8'h00;
      sr2_tgl_q <= 1'b0;
      rp_tgl_q <= 1'b0;
      evt_byte_q <= 8'h00;
      cfg_s1_q <= CFG_RST;
      cfg_s2_q <= CFG_RST;
    end else begin
      cont_q <= cont_d;
      cont_op_q <= cont_op_d;
      sr2_tgl_q <= sr2_tgl_d;
      rp_tgl_q <= rp_tgl_d;
      evt_byte_q <= evt_byte_d;
      cfg_s1_q <= cfg_sys_q;
      cfg_s2_q <= cfg_s1_q;
    end
  end

  // ***************************************************************
  // Lane drive on falling edges
  // ***************************************************************
  logic [3:0] out_d, oe_n_d;
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = mem[ra_q];
    out_d = 4'h0;
    oe_n_d = 4'hf;
    if (st_q == ST_DATA) begin
      case (dw_q)
        W2: begin
          out_d = {2'b00, rd_byte[3'(7 - 2 * beat_q)], rd_byte[3'(6 - 2 * beat_q)]}; // [RL22]
          oe_n_d = 4'hc;
        end
        W4: begin
          out_d = beat_q[0] ? rd_byte[3:0] : rd_byte[7:4];
          oe_n_d = 4'h0;
        end
        default: begin
          out_d = {2'b00, rd_byte[3'(7 - beat_q)], 1'b0}; // [RL5]
          oe_n_d = 4'hd;
        end
      endcase
    end
  end

  always_ff @(negedge sck or posedge frm_rst) begin
    if (frm_rst) begin
      lane_out <= 4'h0;
      lane_oe_n <= 4'hf;
    end else begin
      lane_out <= out_d;
      lane_oe_n <= oe_n_d;
    end
  end

  // ***************************************************************
  // System side status and read parameters
  // ***************************************************************
  logic [2:0] sr2_s_q, rp_s_q;
  fsq_sr2_t sr2_d;
  logic [1:0] rpd_d;
  logic done_d;
  always_comb begin
    sr2_d = sr2;
    rpd_d = read_param_dummy;
    done_d = 1'b0;
    cfg_sys_d = '{quad_en: sr2.quad_lane_enable_bit, busy: busy,
                  four_wire: four_wire_command_mode, dsel: read_param_dummy};
    if ((sr2_s_q[2] ^ sr2_s_q[1]) && write_enable_latch) begin // [RL2]
      sr2_d.complement_protect_bit = evt_byte_q[SR2_COMPL_POS]; // [RL1]
      sr2_d.quad_lane_enable_bit = evt_byte_q[SR2_QUAD_POS]; // [RL1]
      sr2_d.status_protect_bit_high = evt_byte_q[SR2_PROT_POS]; // [RL1]
      done_d = 1'b1;
    end
    if (rp_s_q[2] ^ rp_s_q[1]) begin
      rpd_d = evt_byte_q[RP_DUMMY_LO+1:RP_DUMMY_LO]; // [RL9]
    end
    if (reset_cmd) begin
      rpd_d = DSEL_RST; // [RL10]
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sr2_s_q <= 3'h0;
      rp_s_q <= 3'h0;
      sr2 <= SR2_RST;
      read_param_dummy <= DSEL_RST; // [RL10]
      sr2_write_done <= 1'b0;
      cfg_sys_q <= CFG_RST;
    end else begin
      sr2_s_q <= {sr2_s_q[1:0], sr2_tgl_q};
      rp_s_q <= {rp_s_q[1:0], rp_tgl_q};
      sr2 <= sr2_d;
      read_param_dummy <= rpd_d;
      sr2_write_done <= done_d;
      cfg_sys_q <= cfg_sys_d;
    end
  end
endmodule

/* verilog/fsq_pkg.sv */
/*
  Shared constants and types for the serial flash read and status-2 write sequencer.
  Assumes three importers, the sequencer top, the port checker and the bench, each importing the whole package.
*/
package fsq_pkg;
  // ***************************************************************
  // Opcodes
  // ***************************************************************
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_WR_SR2 = 8'h31;
  localparam logic [7:0] OP_SET_RP = 8'hc0;
  // ***************************************************************
  // Field positions, counts and reset values
  // ***************************************************************
  localparam int MEM_AW = 10;
  localparam logic [4:0] ADDR_BITS = 5'd24;
  localparam logic [4:0] BYTE_BITS = 5'd8;
  localparam logic [4:0] DUMMY_STD = 5'd8;
  localparam logic [4:0] DUMMY_QIO = 5'd4;
  localparam logic [4:0] DUMMY_RP0 = 5'd4;
  localparam logic [4:0] DUMMY_RP1 = 5'd6;
  localparam logic [4:0] DUMMY_RP2 = 5'd8;
  localparam logic [4:0] QIO_MODE_CLKS = 5'd2;
  localparam logic [3:0] CONT_NIBBLE = 4'ha;
  localparam int SR2_COMPL_POS = 6;
  localparam int SR2_QUAD_POS = 1;
  localparam int SR2_PROT_POS = 0;
  localparam int RP_DUMMY_LO = 4;
  localparam logic [1:0] DSEL_RST = 2'b00;
  localparam logic [1:0] W1 = 2'd0;
  localparam logic [1:0] W2 = 2'd1;
  localparam logic [1:0] W4 = 2'd2;
  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [5:0] {
    ST_CMD = 6'h01,
    ST_ADDR = 6'h02,
    ST_MODE = 6'h04,
    ST_DUMMY = 6'h08,
    ST_DATA = 6'h10,
    ST_BYTE = 6'h20
  } fsq_state_t;
  typedef struct packed {
    logic complement_protect_bit;
    logic quad_lane_enable_bit;
    logic status_protect_bit_high;
  } fsq_sr2_t;
  localparam fsq_sr2_t SR2_RST = 3'h0;
  typedef struct packed {
    logic quad_en;
    logic busy;
    logic four_wire;
    logic [1:0] dsel;
  } fsq_cfg_t;
  localparam fsq_cfg_t CFG_RST = 5'h00;
endpackage

/* verification/fsq_seq_assertions.sv */
/*
  Port checker for the flash read and status-2 write sequencer.
  Assumes it is bound onto fsq_seq and sees only its ports.
*/
`timescale 1ns/10ps
module fsq_seq_chk
  import fsq_pkg::*;
(
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Reset, active high.
  input wire logic sck, // Serial clock.
  input wire logic cs_n, // Chip select, active low.
  input wire logic [3:0] lane_out, // Lane drive values.
  input wire logic [3:0] lane_oe_n, // Lane enables, low drives.
  input wire logic write_enable_latch, // Write latch.
  input wire logic reset_cmd, // Reset command pulse.
  input wire fsq_sr2_t sr2, // Status-2 bits.
  input wire logic [1:0] read_param_dummy, // Dummy select.
  input wire logic sr2_write_done // Status-2 written.
);
  // ****************************************
  // Link clocks since select fell
  // ****************************************
  logic [3:0] nclk_q;
  always_ff @(posedge sck or posedge cs_n)
    if (cs_n) nclk_q <= 4'h0;
    else if (nclk_q != 4'h8) nclk_q <= nclk_q + 4'h1;

  oe_code_a: assert property (@(posedge clk_sys) disable iff (rst)
    lane_oe_n inside {4'hf, 4'hd, 4'hc, 4'h0}) else $error("bad lane enable code");
  cs_release_a: assert property (@(posedge clk_sys) disable iff (rst)
    cs_n |-> lane_oe_n == 4'hf && lane_out == 4'h0) else $error("lanes driven while idle");
  done_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    sr2_write_done |=> !sr2_write_done) else $error("done longer than one cycle");
  sr2_cause_a: assert property (@(posedge clk_sys) disable iff (rst)
    !$stable(sr2) |-> sr2_write_done || $past(sr2_write_done)) else $error("sr2 moved alone");
  wel_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    sr2_write_done |-> $past(write_enable_latch)) else $error("sr2 written without latch");
  rp_reset_a: assert property (@(posedge clk_sys) disable iff (rst)
    reset_cmd |=> read_param_dummy == 2'b00) else $error("dummy select not restored");
  quad_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    lane_oe_n == 4'h0 |-> sr2.quad_lane_enable_bit) else $error("quad drive without enable");
  cmd_quiet_a: assert property (@(posedge sck) disable iff (rst || cs_n)
    nclk_q < 4'h8 |-> lane_oe_n == 4'hf) else $error("drive during command byte");

  cover property (@(posedge clk_sys) sr2_write_done);
  cover property (@(posedge clk_sys) lane_oe_n == 4'h0);
  cover property (@(posedge clk_sys) lane_oe_n == 4'hc);
endmodule

bind fsq_seq fsq_seq_chk u_fsq_seq_chk (.clk_sys, .rst, .sck, .cs_n, .lane_out,
  .lane_oe_n, .write_enable_latch, .reset_cmd, .sr2, .read_param_dummy, .sr2_write_done);

/* verification/fsq_host.sv */
/*
  Host controller model: makes the link clock and frames.
  Assumes the bench resolves the shared lanes from all enables.
*/
`timescale 1ns/10ps
module fsq_host (
  output logic sck, // Link clock, still and low between frames.
  output logic cs_n, // Chip select.
  output logic [3:0] drv, // Lane drive values.
  output logic [3:0] en, // Lane enables, high drives.
  input wire logic [3:0] pin, // Resolved lane levels.
  input wire logic [3:0] lane_oe_n, // Device lane enables.
  output logic drove // Device drove in this frame.
);
  logic [3:0] smp;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    drv = 4'h0;
    en = 4'h0;
    drove = 1'b0;
  end
  // Period of 30 ns, data changed only after the falling edge.
  task automatic clk1();
    #15 sck = 1'b1;
    smp = pin;
    drove |= ~&lane_oe_n;
    #15 sck = 1'b0;
  endtask
  task automatic start();
    drove = 1'b0;
    #7 cs_n = 1'b0;
  endtask
  task automatic stop();
    #7 cs_n = 1'b1;
    en = 4'h0;
    #40;
  endtask
  task automatic send(input logic [31:0] v, input int n, input int w);
    en = (4'h1 << w) - 4'h1;
    for (int i = n; i > 0; i -= w) begin
      drv = 4'(v >> (i - w));
      clk1();
    end
  endtask
  task automatic recv(output logic [31:0] v, input int n, input int w);
    en = 4'h0;
    v = '0;
    for (int i = 0; i < n; i += w) begin
      clk1();
      v = (v << w) | 32'(w == 1 ? {3'b0, smp[1]} : smp & ((4'h1 << w) - 4'h1));
    end
  endtask
endmodule

/* verification/tb_top.sv */
/*
  Self-checking bench for the sequencer.
  Assumes the host model and the bound port checker.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %0t got %h want %h", $time, g, e); end end
module tb_top
  import fsq_pkg::*;
;
  logic clk_sys = 0, rst = 1, wr_latch = 0, busy = 0, fw = 0, rcmd = 0, ld = 0, tog = 0;
  logic [9:0] la = 0;
  logic [7:0] ldat = 0;
  logic [3:0] lo, oen, drv, en, pin;
  logic sck, cs_n, drove, done;
  logic [1:0] rpd;
  fsq_sr2_t sr2;
  logic [7:0] mem [1024];
  logic [31:0] exp_q [$], res_q [$], g, e;
  int n_errors = 0, n_compared = 0, seed = 32'hee8af93b;
  always #5 clk_sys = ~clk_sys;
  // Released lanes carry a toggling level so stale data never passes.
  always @(sck) tog = ~tog;
  assign pin = (~oen & lo) | (oen & en & drv) | (oen & ~en & {4{tog}});
  fsq_seq u_fsq_seq (.clk_sys, .rst, .sck, .cs_n, .lane_in(pin), .lane_out(lo),
    .lane_oe_n(oen), .write_enable_latch(wr_latch), .busy, .four_wire_command_mode(fw),
    .reset_cmd(rcmd), .load_en(ld), .load_addr(la), .load_data(ldat), .sr2,
    .read_param_dummy(rpd), .sr2_write_done(done));
  fsq_host u_fsq_host (.sck, .cs_n, .drv, .en, .pin, .lane_oe_n(oen), .drove);
  always @(negedge clk_sys) begin
    if (done === 1'b1) res_q.push_back(32'(sr2));
    if (res_q.size() > 0) begin
      g = res_q.pop_front();
      e = exp_q.pop_front();
      `CHK(g, e)
    end
  end
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic blank(); // Lets configuration reach the link side.
    u_fsq_host.start();
    u_fsq_host.send(32'h0, 8, 1);
    u_fsq_host.stop();
  endtask
  task automatic rd(input logic [7:0] op, input int ow, aw, mw, dum, dw,
      input logic [23:0] a, input logic [7:0] m, input int nb, input bit ok);
    logic [31:0] v, x;
    x = 0;
    for (int k = 0; k < nb; k++) x = (x << 8) | 32'(mem[10'(a + 24'(k))]);
    u_fsq_host.start();
    if (ow > 0) u_fsq_host.send(32'(op), 8, ow);
    u_fsq_host.send(32'(a), 24, aw);
    if (mw > 0) u_fsq_host.send(32'(m), 8, mw);
    u_fsq_host.recv(v, dum * dw, dw);
    u_fsq_host.recv(v, 8 * nb, dw);
    u_fsq_host.stop();
    exp_q.push_back(ok ? x : 32'h0);
    res_q.push_back(ok ? v : 32'(u_fsq_host.drove));
    $display("read test %h done", op);
  endtask
  task automatic wr(input logic [7:0] op, b, input int w);
    u_fsq_host.start();
    u_fsq_host.send(32'(op), 8, w);
    u_fsq_host.send(32'(b), 8, w);
    u_fsq_host.stop();
    repeat (12) @(posedge clk_sys);
    $display("write test %h done", op);
  endtask
  initial begin
    #500us;
    n_errors++;
    wrap_up();
  end
  initial begin
    logic [23:0] a;
    logic [7:0] b;
    for (int i = 0; i < 1024; i++) mem[i] = 8'($random(seed));
    repeat (12) @(posedge clk_sys);
    #1 rst = 0;
    for (int i = 0; i < 1024; i++) begin
      @(posedge clk_sys);
      #1 ld = 1;
      la = 10'(i);
      ldat = mem[i];
    end
    @(posedge clk_sys);
    #1 ld = 0;
    blank();
    a = 24'($random(seed)) | 24'h3fe;
    rd(OP_READ, 1, 1, 0, 0, 1, a, 0, 3, 1);
    rd(OP_FAST, 1, 1, 0, 8, 1, a, 0, 2, 1);
    rd(OP_DUAL_OUT, 1, 1, 0, 8, 2, a, 0, 4, 1);
    rd(OP_QUAD_OUT, 1, 1, 0, 8, 4, a, 0, 2, 0);
    rd(OP_QUAD_IO, 1, 4, 4, 4, 4, a, 0, 2, 0);
    @(posedge clk_sys);
    #1 busy = 1;
    blank();
    rd(OP_READ, 1, 1, 0, 0, 1, a, 0, 1, 0);
    @(posedge clk_sys);
    #1 busy = 0;
    exp_q.push_back(32'h0);
    wr(OP_WR_SR2, 8'hff, 1);
    res_q.push_back(32'(sr2));
    @(posedge clk_sys);
    #1 wr_latch = 1;
    b = 8'($random(seed)) | 8'h02;
    exp_q.push_back({29'h0, b[6], b[1], b[0]});
    wr(OP_WR_SR2, b, 1);
    blank();
    rd(OP_QUAD_OUT, 1, 1, 0, 8, 4, a, 0, 4, 1);
    rd(OP_QUAD_IO, 1, 4, 4, 4, 4, a, 8'ha5, 2, 1);
    rd(OP_QUAD_IO, 0, 4, 4, 4, 4, 24'(a + 5), 8'h3c, 2, 1);
    rd(OP_DUAL_IO, 1, 2, 2, 0, 2, a, 8'haf, 3, 1);
    rd(OP_DUAL_IO, 0, 2, 2, 0, 2, 24'(a + 9), 8'h50, 2, 1);
    rd(OP_DUAL_IO, 1, 2, 2, 0, 2, a, 8'ha0, 1, 1);
    u_fsq_host.start();
    u_fsq_host.send(32'(a), 4, 2);
    u_fsq_host.stop();
    rd(OP_FAST, 1, 1, 0, 8, 1, a, 0, 1, 1);
    @(posedge clk_sys);
    #1 fw = 1;
    blank();
    rd(OP_FAST, 4, 4, 0, 4, 4, a, 0, 2, 1);
    for (int k = 0; k < 3; k++) begin
      wr(OP_SET_RP, {2'b0, 2'(k), 4'h0}, 4);
      exp_q.push_back(32'(k));
      res_q.push_back(32'(rpd));
      blank();
      rd(OP_FAST, 4, 4, 0, 4 + 2 * k, 4, a, 0, 2, 1);
    end
    rd(OP_QUAD_IO, 4, 4, 4, 6, 4, a, 8'h00, 2, 1);
    @(posedge clk_sys);
    #1 rcmd = 1;
    @(posedge clk_sys);
    #1 rcmd = 0;
    blank();
    rd(OP_FAST, 4, 4, 0, 4, 4, a, 0, 2, 1);
    for (int t = 0; t < 50 && res_q.size() > 0; t++) @(posedge clk_sys);
    `CHK(32'(exp_q.size()), 32'h0)
    wrap_up();
  end
endmodule
